/* inc/dmia_defs.vh */
// Address map, field positions and reset values of the data memory block
`ifndef DMIA_DEFS_VH
`define DMIA_DEFS_VH
`define DMIA_ADDR_W        8
`define DMIA_DATA_W        8
`define DMIA_PC_W          12
`define DMIA_PW_W          16
`define DMIA_GPR_BASE      8'h80
`define DMIA_GPR_DEPTH     128
`define DMIA_GPR_IDX_W     7
`define DMIA_SFR_TOP_BIT   7
`define DMIA_ZERO          8'h00
`define DMIA_ADR_IND0      8'h00
`define DMIA_ADR_PTR0      8'h01
`define DMIA_ADR_IND1      8'h02
`define DMIA_ADR_PTR1      8'h03
`define DMIA_ADR_WORK      8'h05
`define DMIA_ADR_PCL       8'h06
`define DMIA_ADR_TBLO      8'h07
`define DMIA_ADR_TBRH      8'h08
`define DMIA_ADR_TBHI      8'h09
`define DMIA_PC_RESET      12'h000
`define DMIA_PC_STEP       12'h001
`define DMIA_OP_NONE       3'h0
`define DMIA_OP_WRITE      3'h1
`define DMIA_OP_BSET       3'h2
`define DMIA_OP_BCLR       3'h3
`define DMIA_OP_TABRD      3'h4
`define DMIA_ST_RUN        2'h0
`define DMIA_ST_DUMMY      2'h1
`define DMIA_ST_TABLE      2'h2
`endif

/* verilog/dmia_gpr_ram.v */
// General purpose RAM array, 128 bytes, one write and one read port
`timescale 1ns/1ps
`default_nettype none
`include "dmia_defs.vh"
module dmia_gpr_ram (
  input  wire                         sys_clk,
  input  wire                         wr_en,
  input  wire [`DMIA_GPR_IDX_W-1:0]   wr_idx,
  input  wire [`DMIA_DATA_W-1:0]      wr_data,
  input  wire [`DMIA_GPR_IDX_W-1:0]   rd_idx,
  output wire [`DMIA_DATA_W-1:0]      rd_data
);
  reg [`DMIA_DATA_W-1:0] mem [0:`DMIA_GPR_DEPTH-1];

  // Volatile: no reset, contents unknown at power up
  always @(posedge sys_clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
  end

  assign rd_data = mem[rd_idx];
endmodule // dmia_gpr_ram
`default_nettype wire

/* verilog/dmia_data_mem.v */
// Data memory with indirect ports, pointers, accumulator, PC low and table registers
`timescale 1ns/1ps
`default_nettype none
`include "dmia_defs.vh"
module dmia_data_mem (
  input  wire                         sys_clk,
  input  wire                         resetn,
  input  wire [2:0]                   op,
  input  wire [`DMIA_ADDR_W-1:0]      addr,
  input  wire [`DMIA_DATA_W-1:0]      wr_data,
  input  wire [2:0]                   bit_sel,
  input  wire                         alu_valid,
  input  wire [`DMIA_DATA_W-1:0]      alu_result,
  input  wire                         pc_advance,
  input  wire [`DMIA_PW_W-1:0]        prog_word,
  input  wire                         prog_valid,
  output reg  [`DMIA_DATA_W-1:0]      rd_data,
  output reg  [`DMIA_DATA_W-1:0]      work_value,
  output reg  [`DMIA_PC_W-1:0]        pc,
  output reg                          stall,
  output reg                          prog_req,
  output reg  [`DMIA_PC_W-1:0]        prog_addr
);
  reg  [`DMIA_DATA_W-1:0] pointer_zero;
  reg  [`DMIA_DATA_W-1:0] pointer_one;
  reg  [`DMIA_DATA_W-1:0] table_ptr_low;
  reg  [`DMIA_DATA_W-1:0] table_ptr_high;
  reg  [`DMIA_DATA_W-1:0] table_result_high;
  reg  [1:0]              state;
  reg  [`DMIA_ADDR_W-1:0] tab_dest;
  reg  [`DMIA_ADDR_W-1:0] eff_addr;
  reg                     ind_hit;
  reg  [`DMIA_DATA_W-1:0] next_rd;
  reg  [`DMIA_DATA_W-1:0] old_val;
  reg  [`DMIA_DATA_W-1:0] new_val;
  reg                     do_store;
  reg  [`DMIA_ADDR_W-1:0] st_addr;
  reg  [`DMIA_DATA_W-1:0] st_data;
  wire [`DMIA_DATA_W-1:0] ram_q;
  wire [`DMIA_DATA_W-1:0] bit_mask;
  wire                    busy;

  assign bit_mask = 8'h01 << bit_sel;
  assign busy     = (state != `DMIA_ST_RUN);

  // Resolve indirect ports to pointer contents; one hop only, so a pointer
  // naming a port itself lands on storage-less locations
  always @*
  begin
    eff_addr = addr;
    ind_hit  = 1'b0;
    if (addr == `DMIA_ADR_IND0)
    begin
      eff_addr = pointer_zero;
      ind_hit  = 1'b1;
    end
    else if (addr == `DMIA_ADR_IND1)
    begin
      eff_addr = pointer_one;
      ind_hit  = 1'b1;
    end
  end

  dmia_gpr_ram u_ram (
    .sys_clk (sys_clk),
    .wr_en   (do_store && st_addr[`DMIA_SFR_TOP_BIT]),
    .wr_idx  (st_addr[`DMIA_GPR_IDX_W-1:0]),
    .wr_data (st_data),
    .rd_idx  (eff_addr[`DMIA_GPR_IDX_W-1:0]),
    .rd_data (ram_q)
  );

  // Read decode of the resolved address
  always @*
  begin
    next_rd = `DMIA_ZERO;
    if (eff_addr[`DMIA_SFR_TOP_BIT])
      next_rd = ram_q;
    else
    begin
      case (eff_addr)
        `DMIA_ADR_IND0: next_rd = `DMIA_ZERO;
        `DMIA_ADR_IND1: next_rd = `DMIA_ZERO;
        `DMIA_ADR_PTR0: next_rd = pointer_zero;
        `DMIA_ADR_PTR1: next_rd = pointer_one;
        `DMIA_ADR_WORK: next_rd = work_value;
        `DMIA_ADR_PCL:  next_rd = pc[`DMIA_DATA_W-1:0];
        `DMIA_ADR_TBLO: next_rd = table_ptr_low;
        `DMIA_ADR_TBRH: next_rd = table_result_high;
        `DMIA_ADR_TBHI: next_rd = table_ptr_high;
        default:        next_rd = `DMIA_ZERO;
      endcase
    end
  end

  // Store path: writes, read-modify-write bit ops, and table low byte
  always @*
  begin
    old_val  = next_rd;
    new_val  = wr_data;
    do_store = 1'b0;
    st_addr  = eff_addr;
    st_data  = wr_data;
    if (state == `DMIA_ST_TABLE)
    begin
      do_store = prog_valid;
      st_addr  = tab_dest;
      st_data  = prog_word[`DMIA_DATA_W-1:0];
    end
    else if (!busy)
    begin
      case (op)
        `DMIA_OP_WRITE: new_val = wr_data;
        `DMIA_OP_BSET:  new_val = old_val | bit_mask;
        `DMIA_OP_BCLR:  new_val = old_val & ~bit_mask;
        default:        new_val = wr_data;
      endcase
      do_store = (op == `DMIA_OP_WRITE) || (op == `DMIA_OP_BSET) || (op == `DMIA_OP_BCLR);
      st_data  = new_val;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      pointer_zero      <= `DMIA_ZERO;
      pointer_one       <= `DMIA_ZERO;
      table_ptr_low     <= `DMIA_ZERO;
      table_ptr_high    <= `DMIA_ZERO;
      table_result_high <= `DMIA_ZERO;
      work_value        <= `DMIA_ZERO;
      pc                <= `DMIA_PC_RESET;
      rd_data           <= `DMIA_ZERO;
      state             <= `DMIA_ST_RUN;
      tab_dest          <= `DMIA_ZERO;
      stall             <= 1'b0;
      prog_req          <= 1'b0;
      prog_addr         <= `DMIA_PC_RESET;
    end
    else
    begin
      rd_data <= next_rd;
      // ALU output lands only in the accumulator
      if (alu_valid)
        work_value <= alu_result;
      if (pc_advance && !busy)
        pc <= pc + `DMIA_PC_STEP;
      if (do_store && !st_addr[`DMIA_SFR_TOP_BIT])
      begin
        // Table result register absent from this case: it is read only
        case (st_addr)
          `DMIA_ADR_PTR0: pointer_zero <= st_data;
          `DMIA_ADR_PTR1: pointer_one <= st_data;
          `DMIA_ADR_WORK: work_value <= st_data;
          `DMIA_ADR_PCL:  pc <= {pc[`DMIA_PC_W-1:`DMIA_DATA_W], st_data};
          `DMIA_ADR_TBLO: table_ptr_low <= st_data;
          `DMIA_ADR_TBHI: table_ptr_high <= st_data;
          default:        ;
        endcase
      end
      case (state)
        `DMIA_ST_RUN:
        begin
          if (do_store && (st_addr == `DMIA_ADR_PCL))
          begin
            state <= `DMIA_ST_DUMMY;
            stall <= 1'b1;
          end
          else if (op == `DMIA_OP_TABRD)
          begin
            // Pointers assumed loaded by software beforehand
            state     <= `DMIA_ST_TABLE;
            tab_dest  <= eff_addr;
            stall     <= 1'b1;
            prog_req  <= 1'b1;
            prog_addr <= {table_ptr_high[`DMIA_PC_W-`DMIA_DATA_W-1:0], table_ptr_low};
          end
        end
        `DMIA_ST_DUMMY:
        begin
          state <= `DMIA_ST_RUN;
          stall <= 1'b0;
        end
        `DMIA_ST_TABLE:
        begin
          prog_req <= 1'b0;
          if (prog_valid)
          begin
            table_result_high <= prog_word[`DMIA_PW_W-1:`DMIA_DATA_W];
            state             <= `DMIA_ST_RUN;
            stall             <= 1'b0;
          end
        end
        default:
        begin
          state <= `DMIA_ST_RUN;
          stall <= 1'b0;
        end
      endcase
    end
  end
endmodule // dmia_data_mem
`default_nettype wire

/* tb/dmia_chk.sv */
// Port-level assertions for the data memory block
`timescale 1ns/1ps
`default_nettype none
module dmia_chk (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [2:0]  op,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wr_data,
  input wire logic        alu_valid,
  input wire logic [7:0]  alu_result,
  input wire logic        pc_advance,
  input wire logic        prog_valid,
  input wire logic [7:0]  rd_data,
  input wire logic [7:0]  work_value,
  input wire logic [11:0] pc,
  input wire logic        stall,
  input wire logic        prog_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire pcl_wr = !stall && op == 3'h1 && addr == 8'h06;
  wire acc_wr = !stall && op == 3'h1 && addr == 8'h05;
  sequence s_gpr_wr;
    !stall && op == 3'h1 && addr[7];
  endsequence
  sequence s_rd_same;
    op == 3'h0 && $stable(addr);
  endsequence
  AST_GPR_RW: assert property (s_gpr_wr ##1 s_rd_same |=> rd_data == $past(wr_data, 2))
    else $error("RAM read back differs from write");
  AST_PCL_STALL: assert property (pcl_wr |=> stall ##1 !stall)
    else $error("PC low write without one dummy cycle");
  AST_PCL_JUMP: assert property (pcl_wr && !pc_advance |=> pc == {$past(pc[11:8]), $past(wr_data)})
    else $error("PC low write wrong jump");
  AST_RD_UNUSED: assert property (!stall && op != 3'h4 && addr == 8'h04 |=> rd_data == 8'h00)
    else $error("Unused location not zero");
  AST_TBL_REQ: assert property (!stall && op == 3'h4 |=> prog_req && stall)
    else $error("Table read not requested");
  AST_REQ_PULSE: assert property (prog_req |=> !prog_req)
    else $error("Request longer than one cycle");
  AST_TBL_END: assert property (stall && prog_valid |=> !stall)
    else $error("Stall kept after table word");
  AST_ALU_LOAD: assert property (alu_valid && !stall && !acc_wr |=> work_value == $past(alu_result))
    else $error("ALU result not in accumulator");
  AST_WORK_WR: assert property (acc_wr |=> work_value == $past(wr_data))
    else $error("Accumulator store lost");
endmodule // dmia_chk
bind dmia_data_mem dmia_chk i_chk (.sys_clk(sys_clk), .resetn(resetn), .op(op), .addr(addr), .wr_data(wr_data),
  .alu_valid(alu_valid), .alu_result(alu_result), .pc_advance(pc_advance), .prog_valid(prog_valid),
  .rd_data(rd_data), .work_value(work_value), .pc(pc), .stall(stall), .prog_req(prog_req));
`default_nettype wire

/* tb/dmia_prog_model.sv */
// Program memory responder for table reads
`timescale 1ns/1ps
`default_nettype none
module dmia_prog_model (
  input  wire logic        sys_clk,
  input  wire logic        prog_req,
  input  wire logic [11:0] prog_addr,
  input  wire logic [1:0]  lag,
  output var  logic [15:0] prog_word = '0,
  output var  logic        prog_valid = 1'b0
);
  logic [1:0]  wait_cnt = '0;
  logic        busy = 1'b0;
  logic [11:0] held = '0;
  always @(posedge sys_clk)
  begin
    prog_valid <= 1'b0;
    // Word toggles outside the answer cycle so a late sample shows
    prog_word <= ~prog_word;
    if (prog_req)
    begin
      busy <= 1'b1;
      wait_cnt <= lag;
      held <= prog_addr;
    end
    else if (busy && wait_cnt != 2'h0)
      wait_cnt <= wait_cnt - 2'h1;
    else if (busy)
    begin
      busy <= 1'b0;
      prog_valid <= 1'b1;
      prog_word <= {held[7:0] ^ 8'h5a, held[11:8], held[3:0]};
    end
  end
endmodule // dmia_prog_model
`default_nettype wire

/* tb/data_memory_indirect_access_test.sv */
// Directed bench for the data memory block
`timescale 1ns/1ps
`default_nettype none
module data_memory_indirect_access_test;
  logic        sys_clk = 1'b0, resetn = 1'b0, alu_valid = 1'b0, pc_advance = 1'b0;
  logic [2:0]  op = '0, bit_sel = '0;
  logic [7:0]  addr = '0, wr_data = '0, alu_result = '0;
  logic [1:0]  lag = '0;
  wire  [7:0]  rd_data, work_value;
  wire  [11:0] pc, prog_addr;
  wire  [15:0] prog_word;
  wire         stall, prog_req, prog_valid;
  int          mismatches = 0, check_count = 0;
  always #20 sys_clk = ~sys_clk;
  dmia_data_mem i_dut (.sys_clk(sys_clk), .resetn(resetn), .op(op), .addr(addr), .wr_data(wr_data),
    .bit_sel(bit_sel), .alu_valid(alu_valid), .alu_result(alu_result), .pc_advance(pc_advance),
    .prog_word(prog_word), .prog_valid(prog_valid), .rd_data(rd_data), .work_value(work_value), .pc(pc),
    .stall(stall), .prog_req(prog_req), .prog_addr(prog_addr));
  dmia_prog_model i_mem (.sys_clk(sys_clk), .prog_req(prog_req), .prog_addr(prog_addr), .lag(lag),
    .prog_word(prog_word), .prog_valid(prog_valid));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] o = 3'h1);
    op = o;
    addr = a;
    wr_data = d;
    step(1);
    op = 3'h0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    step(1);
    chk(rd_data, e);
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_gpr;
    wr(8'h85, 8'h3c);
    rdx(8'h85, 8'h3c);
    bit_sel = 3'h0;
    wr(8'h85, 8'h00, 3'h2);
    rdx(8'h85, 8'h3d);
    bit_sel = 3'h5;
    wr(8'h85, 8'hff, 3'h3);
    rdx(8'h85, 8'h1d);
    wr(8'hff, 8'ha6);
    rdx(8'hff, 8'ha6);
    wr(8'h7f, 8'ha6);
    rdx(8'h7f, 8'h00);
    wr(8'h04, 8'hab);
    rdx(8'h04, 8'h00);
    wr(8'h08, 8'hab);
    rdx(8'h08, 8'h00);
  endtask
  task automatic t_ptr;
    wr(8'h01, 8'h90);
    rdx(8'h01, 8'h90);
    wr(8'h00, 8'h5e);
    rdx(8'h90, 8'h5e);
    wr(8'h03, 8'h02);
    rdx(8'h02, 8'h00);
    wr(8'h03, 8'h90);
    rdx(8'h03, 8'h90);
    rdx(8'h02, 8'h5e);
    wr(8'h02, 8'h21);
    rdx(8'h90, 8'h21);
    wr(8'h01, 8'h00);
    rdx(8'h00, 8'h00);
  endtask
  task automatic t_pcl;
    pc_advance = 1'b1;
    step(291);
    pc_advance = 1'b0;
    chk(pc, 12'h123);
    wr(8'h06, 8'h45);
    chk(stall, 1'b1);
    chk(pc, 12'h145);
    step(1);
    chk(stall, 1'b0);
  endtask
  task automatic t_alu;
    alu_valid = 1'b1;
    alu_result = 8'hc7;
    step(1);
    alu_valid = 1'b0;
    rdx(8'h05, 8'hc7);
    wr(8'h05, 8'h11);
    chk(work_value, 8'h11);
  endtask
  task automatic t_tbl(input logic [7:0] pl, input logic [7:0] ph, input logic [1:0] l);
    int i;
    wr(8'h07, pl);
    wr(8'h09, ph);
    lag = l;
    wr(8'h88, 8'h00, 3'h4);
    chk(prog_req, 1'b1);
    chk(prog_addr, {ph[3:0], pl});
    for (i = 0; i < 12 && stall !== 1'b0; i++)
      step(1);
    if (stall !== 1'b0)
    begin
      mismatches++;
      report_and_stop;
    end
    else
    begin
      rdx(8'h08, pl ^ 8'h5a);
      rdx(8'h88, {ph[3:0], pl[3:0]});
    end
  endtask
  initial
  begin
    step(12);
    resetn = 1'b1;
    rdx(8'h01, 8'h00);
    rdx(8'h03, 8'h00);
    t_gpr;
    t_ptr;
    t_pcl;
    t_alu;
    t_tbl(8'h34, 8'h2f, 2'h0);
    t_tbl(8'h35, 8'h01, 2'h3);
    report_and_stop;
  end
endmodule // data_memory_indirect_access_test
`default_nettype wire
